// [cdc_device.sv]
// Codec end: two-wire slave, control registers, calibration and power-down
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module cdc_device #(
	parameter int CAL_LEN  = cdc_pkg::CAL_CYCLES,       // Calibration length
	parameter int STOP_LEN = cdc_pkg::MCLK_STOP_CYCLES  // Master clock stall limit
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	// Link
	cdc_link_if.dev                  link,
	// Straps and pins
	input  wire logic                addrSelectPin,
	input  wire logic [1:0]          deemphSelectPins,
	input  wire logic                writeOnlyMode,
	// Clocking and converter state
	input  wire logic                mclk,
	input  wire logic                frameClockSyncOk,
	input  wire logic [7:0]          convStatus,
	// Control outputs
	output logic                     adcPowerdown,
	output logic                     dacPowerdown,
	output logic                     chipPowerdown,
	output logic                     trimInProgress,
	output logic                     clockFault,
	output cdc_pkg::cdc_deemph_t     deemphMode,
	output logic [3:0]               adcFilterMute,
	output logic [7:0]               dacControl,
	output logic [7:0]               dspMode
);
	logic [7:0]       regQ [cdc_pkg::REG_STORE];  // Writable register bytes
	cdc_pkg::cdc_slv_t stQ;                        // Protocol state
	cdc_pkg::cdc_slv_t afterQ;                     // State after the ack slot
	logic [3:0]       cntQ;                        // Bits seen in this byte
	logic [7:0]       shQ;                         // Shift register
	logic [7:0]       ptrQ;                        // Register pointer
	logic             oeQ;                         // Pull data low
	logic             sclQ;                        // Last clock level
	logic             sdaQ;                        // Last data level
	logic [31:0]      calCntQ;                     // Calibration timer
	logic             trimQ;                       // Calibration running
	logic             mclkQ;                       // Last master clock level
	logic [15:0]      stallQ;                      // Cycles without mclk edge
	logic             faultQ;                      // Clocking error
	logic             chipDownQ;                   // Whole chip down
	logic             adcDownQ;
	logic             dacDownQ;
	cdc_pkg::cdc_deemph_t demQ;
	logic             sclRise;
	logic             sclFall;
	logic             startCond;
	logic             stopCond;
	logic             byteDone;
	logic             wrEn;
	logic             calTrig;
	logic [2:0]       idx;
	logic [7:0]       rdByte;

	// Read mux; flags and status come from live state
	function automatic logic [7:0] readReg(input logic [2:0] i, input logic [7:0] adc,
		input logic [7:0] st, input logic trim, input logic flt, input logic [7:0] other);
		logic [7:0] v;
		v = other;
		if (i == cdc_pkg::REG_ADC) begin
			v = {adc[7:2], trim, flt};
		end else if (i == cdc_pkg::REG_STAT) begin
			v = st;
		end else if (i > cdc_pkg::REG_STAT) begin
			v = cdc_pkg::RESET_BYTE;
		end
		return v;
	endfunction

	// Bus conditions, pins are synchronous to ref_clk
	assign sclRise   = link.sclLine && !sclQ;
	assign sclFall   = !link.sclLine && sclQ;
	assign startCond = sclQ && link.sclLine && sdaQ && !link.sdaLine;
	assign stopCond  = sclQ && link.sclLine && !sdaQ && link.sdaLine;
	assign byteDone  = sclFall && (cntQ == 4'h8) && !startCond && !stopCond;
	assign idx       = ptrQ[2:0];
	assign rdByte    = readReg(idx, regQ[cdc_pkg::REG_ADC], convStatus, trimQ, faultQ,
		(idx < cdc_pkg::REG_STAT) ? regQ[idx] : cdc_pkg::RESET_BYTE);
	assign wrEn      = byteDone && (stQ == cdc_pkg::SL_WDAT);
	assign calTrig   = wrEn && (idx == cdc_pkg::REG_ADC) && shQ[cdc_pkg::ADC_CAL_BIT]
		&& !regQ[cdc_pkg::REG_ADC][cdc_pkg::ADC_CAL_BIT];
	assign link.devSdaOut = 1'b0;
	assign link.devSdaOe  = oeQ;

	// Line history for edge and start/stop detection
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= link.sclLine;
			sdaQ <= link.sdaLine;
		end
	end

	// Slave protocol engine
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stQ    <= cdc_pkg::SL_IDLE;
			afterQ <= cdc_pkg::SL_IDLE;
			cntQ   <= 4'h0;
			shQ    <= cdc_pkg::RESET_BYTE;
			ptrQ   <= cdc_pkg::RESET_BYTE;
			oeQ    <= 1'b0;
		end else if (stopCond) begin
			// Stop ends any transfer
			stQ <= cdc_pkg::SL_IDLE;
			oeQ <= 1'b0;
		end else if (startCond) begin
			// Start or repeated start
			stQ  <= cdc_pkg::SL_ADDR;
			cntQ <= 4'h0;
			oeQ  <= 1'b0;
		end else begin
			case (stQ)
				cdc_pkg::SL_ADDR, cdc_pkg::SL_PTR, cdc_pkg::SL_WDAT: begin
					if (sclRise) begin
						shQ  <= {shQ[6:0], link.sdaLine};
						cntQ <= cntQ + 4'h1;
					end else if (byteDone) begin
						cntQ <= 4'h0;
						stQ  <= cdc_pkg::SL_ACK;
						oeQ  <= 1'b1;
						if (stQ == cdc_pkg::SL_ADDR) begin
							// Foreign address or refused read: stay silent
							if (shQ[7:1] != {cdc_pkg::DEV_ADDR_HI, addrSelectPin}
								|| (shQ[0] && writeOnlyMode)) begin
								stQ <= cdc_pkg::SL_IDLE;
								oeQ <= 1'b0;
							end
							afterQ <= shQ[0] ? cdc_pkg::SL_RDAT : cdc_pkg::SL_PTR;
						end else if (stQ == cdc_pkg::SL_PTR) begin
							ptrQ   <= shQ;
							afterQ <= cdc_pkg::SL_WDAT;
						end else begin
							afterQ <= cdc_pkg::SL_WDAT;
							if (ptrQ[cdc_pkg::PTR_INC_BIT]) begin
								ptrQ[2:0] <= ptrQ[2:0] + 3'h1;
							end
						end
					end
				end
				cdc_pkg::SL_ACK: begin
					if (sclFall) begin
						stQ  <= afterQ;
						cntQ <= 4'h0;
						oeQ  <= 1'b0;
						if (afterQ == cdc_pkg::SL_RDAT) begin
							// Load selected byte and present its top bit
							shQ <= rdByte;
							oeQ <= !rdByte[7];
							if (ptrQ[cdc_pkg::PTR_INC_BIT]) begin
								ptrQ[2:0] <= ptrQ[2:0] + 3'h1;
							end
						end
					end
				end
				cdc_pkg::SL_RDAT: begin
					if (sclRise) begin
						cntQ <= cntQ + 4'h1;
					end else if (sclFall) begin
						if (cntQ == 4'h8) begin
							// Release for the host's acknowledge
							oeQ <= 1'b0;
							stQ <= cdc_pkg::SL_RACK;
						end else begin
							oeQ <= !shQ[6];
							shQ <= {shQ[6:0], 1'b0};
						end
					end
				end
				cdc_pkg::SL_RACK: begin
					if (sclRise) begin
						// Host ack asks for another byte, nack ends it
						stQ    <= link.sdaLine ? cdc_pkg::SL_IDLE : cdc_pkg::SL_ACK;
						afterQ <= cdc_pkg::SL_RDAT;
					end
				end
				default: begin
					oeQ <= 1'b0;
				end
			endcase
		end
	end

	// Register file; flag bits are stored but read from live state, status byte is not stored
	generate
		for (genvar g = 0; g < cdc_pkg::REG_STORE; g++) begin : gReg
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					regQ[g] <= cdc_pkg::RESET_BYTE;
				end else if (wrEn && idx == 3'(g)) begin
					regQ[g] <= shQ;
				end
			end
		end
	endgenerate

	// Offset calibration, starts on reset release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			trimQ   <= 1'b1;
			calCntQ <= 32'h0000_0000;
		end else if (calTrig) begin
			trimQ   <= 1'b1;
			calCntQ <= 32'h0000_0000;
		end else if (trimQ) begin
			if (calCntQ == 32'(CAL_LEN - 1)) begin
				trimQ <= 1'b0;
			end else begin
				calCntQ <= calCntQ + 32'h0000_0001;
			end
		end
	end

	// Master clock watchdog; mclk must not exceed half of ref_clk
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mclkQ  <= 1'b0;
			stallQ <= 16'h0000;
			faultQ <= 1'b0;
		end else begin
			mclkQ <= mclk;
			if (mclk != mclkQ) begin
				stallQ <= 16'h0000;
			end else if (stallQ != 16'(STOP_LEN)) begin
				stallQ <= stallQ + 16'h0001;
			end
			faultQ <= (stallQ == 16'(STOP_LEN)) || !frameClockSyncOk;
		end
	end

	// Power-down state; register contents are left alone
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			chipDownQ <= 1'b1;
			adcDownQ  <= 1'b1;
			dacDownQ  <= 1'b1;
		end else begin
			chipDownQ <= faultQ || (regQ[cdc_pkg::REG_ADC][cdc_pkg::ADC_PD_BIT]
				&& regQ[cdc_pkg::REG_DAC][cdc_pkg::DAC_PD_BIT]);
			adcDownQ  <= faultQ || regQ[cdc_pkg::REG_ADC][cdc_pkg::ADC_PD_BIT];
			dacDownQ  <= faultQ || regQ[cdc_pkg::REG_DAC][cdc_pkg::DAC_PD_BIT];
		end
	end

	// De-emphasis source; unused codes fall to off
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			demQ <= cdc_pkg::DE_OFF;
		end else begin
			case (regQ[cdc_pkg::REG_DSP][cdc_pkg::DSP_DEM_HI:cdc_pkg::DSP_DEM_LO])
				cdc_pkg::DEM_SRC_PINS: begin
					case (deemphSelectPins)
						cdc_pkg::DEM_PIN_32: demQ <= cdc_pkg::DE_32K;
						cdc_pkg::DEM_PIN_44: demQ <= cdc_pkg::DE_44K;
						cdc_pkg::DEM_PIN_48: demQ <= cdc_pkg::DE_48K;
						default:             demQ <= cdc_pkg::DE_OFF;
					endcase
				end
				cdc_pkg::DEM_SRC_44: demQ <= cdc_pkg::DE_44K;
				cdc_pkg::DEM_SRC_48: demQ <= cdc_pkg::DE_48K;
				cdc_pkg::DEM_SRC_32: demQ <= cdc_pkg::DE_32K;
				default:             demQ <= cdc_pkg::DE_OFF;
			endcase
		end
	end

	// Outputs, all from flip-flops
	assign adcPowerdown   = adcDownQ;
	assign dacPowerdown   = dacDownQ;
	assign chipPowerdown  = chipDownQ;
	assign trimInProgress = trimQ;
	assign clockFault     = faultQ;
	assign deemphMode     = demQ;
	assign adcFilterMute  = regQ[cdc_pkg::REG_ADC][cdc_pkg::ADC_HPR_BIT:cdc_pkg::ADC_ML_BIT];
	assign dacControl     = regQ[cdc_pkg::REG_DAC];
	assign dspMode        = regQ[cdc_pkg::REG_DSP];
endmodule

// [cdc_host.sv]
// Host end: APB-driven two-wire master with codec reset sequencing
`timescale 1ns/1ps
module cdc_host #(
	parameter int   HOLD_LEN  = cdc_pkg::RST_HOLD_CYCLES, // Codec reset hold
	parameter int   QTR_LEN   = cdc_pkg::QTR_CYCLES,      // Quarter bit time
	parameter logic ADDR_SEL  = 1'b0                      // Codec strap level
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Link
	cdc_link_if.host         link,
	// Codec reset
	output logic             codecRst_b,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	logic [31:0]       holdQ;     // Reset hold timer
	logic              rstDoneQ;  // Codec out of reset
	logic              initDoneQ; // Reserved byte write started
	logic [6:0]        cmdAddrQ;  // Software device address
	logic              cmdRdQ;
	logic              cmdWdQ;
	logic [7:0]        ptrByteQ;
	logic [7:0]        wrByteQ;
	logic [7:0]        rdByteQ;
	logic              nackQ;
	cdc_pkg::cdc_mst_t stQ;
	logic [1:0]        phQ;       // Quarter phase
	logic [15:0]       qCntQ;
	logic [3:0]        bitQ;
	logic [1:0]        byteQ;
	logic [6:0]        actAddrQ;  // Latched transfer
	logic              actRdQ;
	logic [1:0]        lastQ;
	logic [7:0]        actPtrQ;
	logic [7:0]        actWdQ;
	logic              sclQ;
	logic              sdaOeQ;
	logic              apbWr;
	logic              swGo;
	logic              autoGo;
	logic              tick;
	logic [7:0]        txByte;
	logic              rxNow;

	assign pready  = 1'b1;
	assign apbWr   = psel && penable && pwrite;
	assign pslverr = psel && penable && (paddr != cdc_pkg::HOFS_CMD)
		&& (paddr != cdc_pkg::HOFS_DATA) && (paddr != cdc_pkg::HOFS_STATUS);
	assign swGo    = apbWr && (paddr == cdc_pkg::HOFS_CMD) && pwdata[cdc_pkg::CMD_GO_BIT]
		&& rstDoneQ && initDoneQ && (stQ == cdc_pkg::MS_IDLE);
	assign autoGo  = rstDoneQ && !initDoneQ && (stQ == cdc_pkg::MS_IDLE);
	assign tick    = (qCntQ == 16'(QTR_LEN - 1));
	assign rxNow   = actRdQ && (byteQ == 2'h1);
	assign txByte  = (byteQ == 2'h0) ? {actAddrQ, actRdQ}
		: (byteQ == 2'h1) ? actPtrQ : actWdQ;
	assign link.sclOut     = sclQ;
	assign link.hostSdaOut = 1'b0;
	assign link.hostSdaOe  = sdaOeQ;
	assign codecRst_b      = rstDoneQ;

	// Read mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (paddr == cdc_pkg::HOFS_CMD) begin
			prdata = {17'h0_0000, cmdAddrQ, 5'h00, cmdWdQ, cmdRdQ, 1'b0};
		end else if (paddr == cdc_pkg::HOFS_DATA) begin
			prdata = {16'h0000, wrByteQ, ptrByteQ};
		end else if (paddr == cdc_pkg::HOFS_STATUS) begin
			prdata = {16'h0000, rdByteQ, 5'h00, rstDoneQ, nackQ, stQ != cdc_pkg::MS_IDLE};
		end
	end

	// Hold codec in reset after own reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			holdQ    <= 32'h0000_0000;
			rstDoneQ <= 1'b0;
		end else if (!rstDoneQ) begin
			if (holdQ == 32'(HOLD_LEN - 1)) begin
				rstDoneQ <= 1'b1;
			end else begin
				holdQ <= holdQ + 32'h0000_0001;
			end
		end
	end

	// Software registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdAddrQ <= {cdc_pkg::DEV_ADDR_HI, ADDR_SEL};
			cmdRdQ   <= 1'b0;
			cmdWdQ   <= 1'b0;
			ptrByteQ <= cdc_pkg::RESET_BYTE;
			wrByteQ  <= cdc_pkg::RESET_BYTE;
		end else if (apbWr && paddr == cdc_pkg::HOFS_CMD) begin
			cmdAddrQ <= pwdata[14:8];
			cmdRdQ   <= pwdata[cdc_pkg::CMD_RD_BIT];
			cmdWdQ   <= pwdata[cdc_pkg::CMD_WD_BIT];
		end else if (apbWr && paddr == cdc_pkg::HOFS_DATA) begin
			ptrByteQ <= pwdata[7:0];
			wrByteQ  <= pwdata[15:8];
		end
	end

	// Bit engine: four quarter phases per bit
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stQ <= cdc_pkg::MS_IDLE;
			phQ <= 2'h0;
			qCntQ <= 16'h0000;
			bitQ <= 4'h0;
			byteQ <= 2'h0;
			sclQ <= 1'b1;
			sdaOeQ <= 1'b0;
			nackQ <= 1'b0;
			rdByteQ <= cdc_pkg::RESET_BYTE;
			initDoneQ <= 1'b0;
			actAddrQ <= 7'h00;
			actRdQ <= 1'b0;
			lastQ <= 2'h0;
			actPtrQ <= cdc_pkg::RESET_BYTE;
			actWdQ <= cdc_pkg::RESET_BYTE;
		end else if (stQ == cdc_pkg::MS_IDLE) begin
			qCntQ <= 16'h0000;
			phQ   <= 2'h0;
			if (autoGo) begin
				// First job: reserved byte to zero
				actAddrQ  <= {cdc_pkg::DEV_ADDR_HI, ADDR_SEL};
				actRdQ    <= 1'b0;
				actPtrQ   <= {5'h00, cdc_pkg::REG_RSVD};
				actWdQ    <= cdc_pkg::RESET_BYTE;
				lastQ     <= 2'h2;
				initDoneQ <= 1'b1;
				nackQ     <= 1'b0;
				stQ       <= cdc_pkg::MS_START;
			end else if (swGo) begin
				actAddrQ <= pwdata[14:8];
				actRdQ   <= pwdata[cdc_pkg::CMD_RD_BIT];
				actPtrQ  <= ptrByteQ;
				actWdQ   <= wrByteQ;
				lastQ    <= (pwdata[cdc_pkg::CMD_WD_BIT] && !pwdata[cdc_pkg::CMD_RD_BIT])
					? 2'h2 : 2'h1;
				nackQ    <= 1'b0;
				stQ      <= cdc_pkg::MS_START;
			end
		end else begin
			qCntQ <= tick ? 16'h0000 : qCntQ + 16'h0001;
			if (tick) begin
				phQ <= phQ + 2'h1;
				case (stQ)
					cdc_pkg::MS_START: begin
						if (phQ == 2'h1) sdaOeQ <= 1'b1;
						if (phQ == 2'h2) sclQ <= 1'b0;
						if (phQ == 2'h3) begin
							stQ   <= cdc_pkg::MS_BYTE;
							bitQ  <= 4'h0;
							byteQ <= 2'h0;
						end
					end
					cdc_pkg::MS_BYTE: begin
						case (phQ)
							2'h0: sdaOeQ <= (bitQ < 4'h8) && !rxNow && !txByte[3'(4'h7 - bitQ)];
							2'h1: sclQ <= 1'b1;
							2'h2: begin
								// Sample data or acknowledge
								if (bitQ < 4'h8 && rxNow) begin
									rdByteQ <= {rdByteQ[6:0], link.sdaLine};
								end else if (bitQ == 4'h8 && !rxNow && link.sdaLine) begin
									nackQ <= 1'b1;
								end
							end
							default: begin
								sclQ <= 1'b0;
								bitQ <= bitQ + 4'h1;
								if (bitQ == 4'h8) begin
									bitQ <= 4'h0;
									byteQ <= byteQ + 2'h1;
									if (nackQ || byteQ == lastQ) stQ <= cdc_pkg::MS_STOP;
								end
							end
						endcase
					end
					cdc_pkg::MS_STOP: begin
						if (phQ == 2'h0) sdaOeQ <= 1'b1;
						if (phQ == 2'h1) sclQ <= 1'b1;
						if (phQ == 2'h2) sdaOeQ <= 1'b0;
						if (phQ == 2'h3) stQ <= cdc_pkg::MS_IDLE;
					end
					default: stQ <= cdc_pkg::MS_IDLE;
				endcase
			end
		end
	end
endmodule

// [cdc_link_if.sv]
// Two-wire link between the host controller and the codec port
`timescale 1ns/1ps
interface cdc_link_if;
	logic sclOut;      // Clock, driven by host only
	logic hostSdaOut;  // Host data level
	logic hostSdaOe;   // Host drives data
	logic devSdaOut;   // Device data level
	logic devSdaOe;    // Device drives data
	logic sclLine;     // Resolved clock
	logic sdaLine;     // Resolved open-drain data
	assign sclLine = sclOut;
	// Open drain: only a low level is driven, the pull-up wins otherwise
	assign sdaLine = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));
	modport dev(input sclLine, input sdaLine, output devSdaOut, output devSdaOe);
	modport host(input sdaLine, output sclOut, output hostSdaOut, output hostSdaOe);
endinterface

// [cdc_link_sva.sv]
// Protocol checker for the two-wire link between host and codec ends
`timescale 1ns/1ps
module cdc_link_sva #(
	parameter int QTR = 4 // Quarter bit time in reference cycles
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Link signals
	input wire logic sclOut,
	input wire logic hostSdaOut,
	input wire logic hostSdaOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic sclLine,
	input wire logic sdaLine
);
	localparam int SPAN = 4 * QTR;     // Start condition length
	localparam int RUN  = 9 * 4 * QTR; // Longest pull: acknowledge plus eight zero bits
	logic [9:0] lowCnt_q;              // Clock low run
	logic [9:0] oeCnt_q;               // Device pull run
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Run counters; a stuck clock or stuck pull counts up and wraps at 10 bits
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lowCnt_q <= '0;
			oeCnt_q  <= '0;
		end else begin
			lowCnt_q <= sclLine ? '0 : lowCnt_q + 10'h001;
			oeCnt_q  <= devSdaOe ? oeCnt_q + 10'h001 : '0;
		end
	end
	property p_excl; sclLine |-> !(devSdaOe && hostSdaOe); endproperty
	a_excl: assert property (p_excl) else $error("Both ends pull data while clock high");
	property p_rise; $rose(devSdaOe) |-> !sclLine; endproperty
	a_rise: assert property (p_rise) else $error("Device pull starts with clock high");
	property p_hold; sclLine && $past(sclLine) |-> $stable(devSdaOe); endproperty
	a_hold: assert property (p_hold) else $error("Device data moves with clock high");
	property p_run; oeCnt_q <= RUN; endproperty
	a_run: assert property (p_run) else $error("Device pull held too long");
	property p_low; lowCnt_q < SPAN; endproperty
	a_low: assert property (p_low) else $error("Clock low too long");
	property p_start; $fell(sdaLine) && sclLine |-> ##[1:SPAN] !sclLine; endproperty
	a_start: assert property (p_start) else $error("Start not followed by clock");
	property p_stop; $rose(sdaLine) && sclLine |=> !devSdaOe [*2]; endproperty
	a_stop: assert property (p_stop) else $error("Device pulls after stop");
	property p_odrain; devSdaOut == 1'b0 && hostSdaOut == 1'b0; endproperty
	a_odrain: assert property (p_odrain) else $error("Data driven high");
	// Main scenarios reached
	c_ack: cover property ($rose(devSdaOe));
	c_start: cover property ($fell(sdaLine) && sclLine);
	c_stop: cover property ($rose(sdaLine) && sclLine);
endmodule

// [cdc_pkg.sv]
// Shared constants and types for the codec two-wire control port and its host
package cdc_pkg;
	// Bus address and register indices
	localparam logic [5:0] DEV_ADDR_HI = 6'h08;
	localparam logic [2:0] REG_RSVD    = 3'h0;
	localparam logic [2:0] REG_ADC     = 3'h1;
	localparam logic [2:0] REG_DAC     = 3'h2;
	localparam logic [2:0] REG_DSP     = 3'h5;
	localparam logic [2:0] REG_STAT    = 3'h6;
	localparam int         REG_STORE   = 6;
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	// Field positions
	localparam int PTR_INC_BIT  = 7;
	localparam int ADC_PD_BIT   = 7;
	localparam int ADC_HPR_BIT  = 6;
	localparam int ADC_HPL_BIT  = 5;
	localparam int ADC_MR_BIT   = 4;
	localparam int ADC_ML_BIT   = 3;
	localparam int ADC_CAL_BIT  = 2;
	localparam int DAC_PD_BIT   = 7;
	localparam int DSP_DEM_HI   = 7;
	localparam int DSP_DEM_LO   = 5;
	// De-emphasis source field and pin codes
	localparam logic [2:0] DEM_SRC_PINS = 3'h0;
	localparam logic [2:0] DEM_SRC_44   = 3'h1;
	localparam logic [2:0] DEM_SRC_48   = 3'h2;
	localparam logic [2:0] DEM_SRC_32   = 3'h3;
	localparam logic [1:0] DEM_PIN_32   = 2'h0;
	localparam logic [1:0] DEM_PIN_44   = 2'h1;
	localparam logic [1:0] DEM_PIN_48   = 2'h2;
	// Timing at the 125 MHz reference clock
	localparam int CLK_MHZ          = 125;
	localparam int CAL_MS           = 50;
	localparam int CAL_CYCLES       = CAL_MS * 1000 * CLK_MHZ;
	localparam int MCLK_STOP_US     = 10;
	localparam int MCLK_STOP_CYCLES = MCLK_STOP_US * CLK_MHZ;
	localparam int RST_HOLD_MS      = 10;
	localparam int RST_HOLD_CYCLES  = RST_HOLD_MS * 1000 * CLK_MHZ;
	localparam int SCL_KHZ          = 100;
	localparam int QTR_CYCLES       = (CLK_MHZ * 1000 + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
	// Host APB map
	localparam logic [11:0] HOFS_CMD    = 12'h000;
	localparam logic [11:0] HOFS_DATA   = 12'h004;
	localparam logic [11:0] HOFS_STATUS = 12'h008;
	localparam int CMD_GO_BIT   = 0;
	localparam int CMD_RD_BIT   = 1;
	localparam int CMD_WD_BIT   = 2;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_NACK_BIT  = 1;
	localparam int ST_READY_BIT = 2;
	// Types
	typedef enum logic [1:0] {DE_OFF, DE_32K, DE_44K, DE_48K} cdc_deemph_t;
	typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ACK, SL_PTR, SL_WDAT, SL_RDAT, SL_RACK}
		cdc_slv_t;
	typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BYTE, MS_STOP} cdc_mst_t;
endpackage

// [tb_top.sv]
// Self-checking bench for the host and codec ends joined by the link
`timescale 1ns/1ps
module tb_top;
	localparam logic [6:0] DA = {cdc_pkg::DEV_ADDR_HI, 1'b0}; // Codec address, strap low
	localparam logic [2:0] GO = 3'h1; // Pointer load only
	localparam logic [2:0] RC = 3'h3; // Read one byte
	localparam logic [2:0] WC = 3'h5; // Pointer plus data
	localparam cdc_pkg::cdc_deemph_t DM [4] = '{cdc_pkg::DE_32K, cdc_pkg::DE_44K,
		cdc_pkg::DE_48K, cdc_pkg::DE_OFF};
	logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, codecRst_b, err, mclk = 0, mclkRun = 1, wrOnly = 0;
	logic [1:0] pins = '0;
	logic strap = 0, frameOk = 1; // Address strap and frame clock lock
	logic [7:0] stat = 8'hA5, dacCtl, dspM; // Status byte in, register bytes out
	localparam int CAL = 200; // Shortened calibration length
	logic adcPd, dacPd, chipPd, trim, clkFault;
	logic [3:0] fm;
	cdc_pkg::cdc_deemph_t dem;
	int failures = 0;
	int n_compared = 0;
	cdc_link_if link();
	cdc_host #(.HOLD_LEN(20), .QTR_LEN(4)) u_cdc_host(.ref_clk(ref_clk), .rst_b(rst_b),
		.link(link), .codecRst_b(codecRst_b), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// Codec reset comes from the host sequencer
	cdc_device #(.CAL_LEN(CAL), .STOP_LEN(50)) u_cdc_device(.ref_clk(ref_clk),
		.rst_b(codecRst_b), .link(link), .addrSelectPin(strap), .deemphSelectPins(pins),
		.writeOnlyMode(wrOnly), .mclk(mclk), .frameClockSyncOk(frameOk), .convStatus(stat),
		.adcPowerdown(adcPd), .dacPowerdown(dacPd), .chipPowerdown(chipPd),
		.trimInProgress(trim), .clockFault(clkFault), .deemphMode(dem), .adcFilterMute(fm),
		.dacControl(dacCtl), .dspMode(dspM));
	cdc_link_sva #(.QTR(4)) u_cdc_link_sva(.ref_clk(ref_clk), .rst_b(rst_b),
		.sclOut(link.sclOut), .hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe),
		.devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .sclLine(link.sclLine),
		.sdaLine(link.sdaLine));
	initial forever #4 ref_clk = ~ref_clk;
	// Master clock at half rate; mclkRun low models a stopped source
	always @(posedge ref_clk) if (mclkRun) mclk <= ~mclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Load pointer and data, start, poll until idle; rd keeps the last status
	task automatic xfer(input logic [6:0] ad, input logic [2:0] f, input logic [7:0] p,
		input logic [7:0] v);
		// GO is ignored while busy, so wait for idle first
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0) apb(1'b0, cdc_pkg::HOFS_STATUS, 32'h0000_0000);
		apb(1'b1, cdc_pkg::HOFS_DATA, {16'h0000, v, p});
		apb(1'b1, cdc_pkg::HOFS_CMD, {17'h0_0000, ad, 5'h00, f});
		rd = 32'h0000_0001;
		while (rd[0] !== 1'b0) apb(1'b0, cdc_pkg::HOFS_STATUS, 32'h0000_0000);
	endtask
	task automatic rdreg(input logic [7:0] p);
		xfer(DA, GO, p, 8'h00);
		xfer(DA, RC, p, 8'h00);
	endtask
	// Codec held in reset by the host, then calibrates after release
	task automatic t_reset();
		chk(codecRst_b, 1'b0);
		chk(chipPd, 1'b1);
		chk(trim, 1'b1);
		rd = '0;
		while (rd[2] !== 1'b1) apb(1'b0, cdc_pkg::HOFS_STATUS, 32'h0000_0000);
		chk(trim, 1'b1);
		repeat (CAL) @(posedge ref_clk);
		chk(trim, 1'b0);
		rdreg(8'h01);
		chk(rd[15:8], 8'h00);
	endtask
	// Flag bits ignore writes, status byte reads back
	task automatic t_rw();
		xfer(DA, WC, 8'h01, 8'h7B);
		chk(fm, 4'hF);
		rdreg(8'h01);
		chk(rd[15:8], 8'h78);
		stat <= 8'h3C;
		rdreg(8'h06);
		chk(rd[15:8], 8'h3C);
	endtask
	// Increment moves pointer on, fixed pointer stays
	task automatic t_inc();
		xfer(DA, WC, 8'h02, 8'h13);
		chk(dacCtl, 8'h13);
		xfer(DA, WC, 8'h81, 8'h58);
		xfer(DA, RC, 8'h00, 8'h00);
		chk(rd[15:8], 8'h13);
		xfer(DA, WC, 8'h01, 8'h48);
		xfer(DA, RC, 8'h00, 8'h00);
		chk(rd[15:8], 8'h48);
	endtask
	// Stopped master clock powers down, settings survive
	task automatic t_clk();
		mclkRun <= 1'b0;
		repeat (80) @(posedge ref_clk);
		chk(clkFault, 1'b1);
		chk(chipPd, 1'b1);
		mclkRun <= 1'b1;
		repeat (80) @(posedge ref_clk);
		chk(clkFault, 1'b0);
		// Frame slip: fault flag reads live, chip powers down
		frameOk <= 1'b0;
		rdreg(8'h01);
		chk(rd[15:8], 8'h49);
		chk(chipPd, 1'b1);
		frameOk <= 1'b1;
		rdreg(8'h02);
		chk(rd[15:8], 8'h13);
	endtask
	// Only a rising trigger bit restarts calibration
	task automatic t_cal();
		xfer(DA, WC, 8'h01, 8'h04);
		chk(trim, 1'b1);
		repeat (250) @(posedge ref_clk);
		chk(trim, 1'b0);
		xfer(DA, WC, 8'h01, 8'h04);
		chk(trim, 1'b0);
	endtask
	task automatic t_pwr();
		xfer(DA, WC, 8'h01, 8'h80);
		chk({adcPd, chipPd}, 2'b10);
		xfer(DA, WC, 8'h02, 8'h80);
		chk({dacPd, chipPd}, 2'b11);
		xfer(DA, WC, 8'h01, 8'h00);
		chk(chipPd, 1'b0);
	endtask
	// Default source follows the pins; a nonzero source field overrides them
	task automatic t_dem();
		for (int i = 0; i < 4; i++) begin
			pins <= 2'(i);
			repeat (3) @(posedge ref_clk);
			chk(dem, DM[i]);
		end
		xfer(DA, WC, 8'h05, 8'h20);
		chk(dspM, 8'h20);
		chk(dem, cdc_pkg::DE_44K);
		xfer(DA, WC, 8'h05, 8'h00);
		chk(dem, cdc_pkg::DE_OFF);
	endtask
	// Wrong address, read in write-only mode, unmapped register
	task automatic t_refuse();
		xfer(7'h11, GO, 8'h00, 8'h00);
		chk(rd[1], 1'b1);
		strap <= 1'b1;
		xfer(7'h11, GO, 8'h00, 8'h00);
		chk(rd[1], 1'b0);
		strap <= 1'b0;
		wrOnly <= 1'b1;
		xfer(DA, RC, 8'h00, 8'h00);
		chk(rd[1], 1'b1);
		wrOnly <= 1'b0;
		xfer(DA, GO, 8'h01, 8'h00);
		chk(rd[1], 1'b0);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk(err, 1'b1);
	endtask
	task automatic wrap_up();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_dem();
		t_rw();
		t_inc();
		t_clk();
		t_cal();
		t_pwr();
		t_refuse();
		wrap_up();
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		wrap_up();
	end
endmodule
